// ==== rtl/xlate_pkg.sv ====
// Purpose: Shared constants and types of the region address translator
// Assumes: 64-bit virtual addresses, 4 KB smallest page, word-wide AHB-Lite registers
// Notes: Register offsets are byte addresses within the slave window
package xlate_pkg;
  // Sizes
  localparam int unsigned REGION_CNT = 8;
  localparam int unsigned TB_ENTRIES = 4;
  localparam int unsigned TAG_W = 24;
  localparam int unsigned VPN_W = 49;
  localparam int unsigned FRAME_W = 52;
  localparam logic [5:0] MIN_PS = 6'd12;
  // Register offsets
  localparam logic [7:0] OFS_REGION0 = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h20;
  localparam logic [7:0] OFS_HBASE_LO = 8'h24;
  localparam logic [7:0] OFS_HBASE_HI = 8'h28;
  localparam logic [7:0] OFS_HEA_LO = 8'h2C;
  localparam logic [7:0] OFS_HEA_HI = 8'h30;
  localparam logic [7:0] OFS_INS_INFO = 8'h34;
  localparam logic [7:0] OFS_INS_VA_LO = 8'h38;
  localparam logic [7:0] OFS_INS_VA_HI = 8'h3C;
  localparam logic [7:0] OFS_PTE_LO = 8'h40;
  localparam logic [7:0] OFS_PTE_HI = 8'h44;
  localparam logic [7:0] OFS_INS_CMD = 8'h48;
  localparam logic [7:0] OFS_KEY0 = 8'h4C;
  localparam logic [7:0] OFS_KEY1 = 8'h50;
  localparam logic [7:0] OFS_STATUS = 8'h54;
  localparam logic [7:0] OFS_CLEAR = 8'h58;
  localparam logic [7:0] OFS_ENABLE = 8'h5C;
  // Region register and insertion info fields
  localparam int unsigned RR_WALK_BIT = 0;
  localparam int unsigned PS_LSB = 2;
  localparam int unsigned TAG_LSB = 8;
  localparam logic [31:0] RR_RESET = 32'h0000_0030;
  // Control register bits
  localparam int unsigned CTL_IT = 0;
  localparam int unsigned CTL_DT = 1;
  localparam int unsigned CTL_RT = 2;
  localparam int unsigned CTL_IC = 3;
  localparam int unsigned CTL_RNM = 4;
  localparam int unsigned CTL_KEY = 5;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // Page table entry word fields
  localparam int unsigned PTE_PRESENT = 0;
  localparam int unsigned PTE_PL_LSB = 1;
  localparam int unsigned PTE_R = 3;
  localparam int unsigned PTE_W = 4;
  localparam int unsigned PTE_X = 5;
  localparam int unsigned PTE_PS_LSB = 6;
  localparam int unsigned PTE_FRAME_LSB = 12;
  // Protection key register fields
  localparam int unsigned KEY_VALID = 0;
  localparam int unsigned KEY_RD = 1;
  localparam int unsigned KEY_WR = 2;
  localparam int unsigned KEY_EX = 3;
  // Status bits
  localparam int unsigned ST_MISS = 0;
  localparam int unsigned ST_ACC = 1;
  localparam int unsigned ST_WALK = 2;
  localparam int unsigned ST_DONE = 3;
  // Reference classes
  typedef enum logic [1:0] {
    REF_FETCH = 2'h0,
    REF_DATA = 2'h1,
    REF_STACK = 2'h2
  } ref_class_t;
  // Sequencer states
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_LOOK = 3'b010,
    S_WALK = 3'b100
  } xl_state_t;
endpackage : xlate_pkg

// ==== rtl/hash_addr_gen.sv ====
// Purpose: Forms the hash table entry address for a page number and region tag
// Assumes: Table base aligned to 32 KB, 8-byte entries
// Notes: Purely combinational
`timescale 1ns/10ps
module hash_addr_gen
  import xlate_pkg::*;
(
  // Table and key
  input wire logic [63:0] base,
  input wire logic [TAG_W-1:0] tag,
  input wire logic [VPN_W-1:0] page_number_field,
  // Result
  output logic [63:0] addr
);
  // Folding the tag in spreads regions over the table
  logic [11:0] idx;
  assign idx = page_number_field[11:0] ^ tag[11:0] ^ tag[23:12];
  assign addr = {base[63:15], idx, 3'b000};
endmodule : hash_addr_gen

// ==== rtl/prot_key_check.sv ====
// Purpose: Checks an entry key against two protection key registers
// Assumes: Key registers use the insertion info layout for the tag
// Notes: Passes everything while the check is switched off
`timescale 1ns/10ps
module prot_key_check
  import xlate_pkg::*;
(
  // Setup
  input wire logic check_en,
  input wire logic [31:0] key0,
  input wire logic [31:0] key1,
  // Access
  input wire logic [TAG_W-1:0] entry_key,
  input wire logic need_r,
  input wire logic need_w,
  input wire logic need_x,
  // Verdict
  output logic ok
);
  // One key register grants if valid, tag matches and every needed right is set
  function automatic logic grants(input logic [31:0] k, input logic [TAG_W-1:0] t,
                                  input logic r, input logic w, input logic x);
    grants = k[KEY_VALID] && (k[TAG_LSB +: TAG_W] == t) && (!r || k[KEY_RD])
             && (!w || k[KEY_WR]) && (!x || k[KEY_EX]);
  endfunction : grants
  assign ok = !check_en || grants(key0, entry_key, need_r, need_w, need_x)
              || grants(key1, entry_key, need_r, need_w, need_x);
endmodule : prot_key_check

// ==== rtl/region_virtual_address_translator.sv ====
// Purpose: Region tagged virtual to physical translation with hash table walk
// Assumes: One request at a time; walk memory answers with walk_ack
// Notes: Registers reached over AHB-Lite, zero wait states
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/10ps
module region_virtual_address_translator
  import xlate_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  // Translation request
  input wire logic req_valid,
  input wire logic [1:0] req_class,
  input wire logic req_legacy32,
  input wire logic [63:0] req_vaddr,
  input wire logic req_write,
  input wire logic [1:0] req_pl,
  output logic req_ready,
  // Translation answer
  output logic resp_valid,
  output logic [63:0] resp_paddr,
  output logic resp_fault,
  output logic resp_access_fault,
  // Hash table memory reads
  output logic walk_valid,
  output logic [63:0] walk_addr,
  input wire logic walk_ack,
  input wire logic [63:0] walk_data
);
  // Region, control and software insert state
  logic [31:0] rr_q [REGION_CNT];
  logic [31:0] rr_d [REGION_CNT];
  logic [31:0] ctrl_q, ctrl_d, ins_info_q, ins_info_d, key0_q, key0_d, key1_q, key1_d;
  logic [63:0] hbase_q, hbase_d, ins_va_q, ins_va_d, pte_q, pte_d;
  logic [63:2] hea_q, hea_d; // Only the upper 62 bits exist
  logic [3:0] st_q, st_d, en_q, en_d, st_set;
  // Translation buffer entries
  logic tb_valid_q [TB_ENTRIES], tb_valid_d [TB_ENTRIES];
  logic [2:0] tb_rn_q [TB_ENTRIES], tb_rn_d [TB_ENTRIES];
  logic [TAG_W-1:0] tb_tag_q [TB_ENTRIES], tb_tag_d [TB_ENTRIES];
  logic [VPN_W-1:0] tb_vpn_q [TB_ENTRIES], tb_vpn_d [TB_ENTRIES];
  logic [63:0] tb_pte_q [TB_ENTRIES], tb_pte_d [TB_ENTRIES];
  logic [1:0] vic_q, vic_d; // Round-robin victim for walk installs
  // Request sequencer
  xl_state_t state_q, state_d;
  logic [63:0] va_q, va_d;
  logic [1:0] cls_q, cls_d, pl_q, pl_d;
  logic wr_q, wr_d, walked_q, walked_d;
  // Registered outputs
  logic rdy_q, rdy_d, rv_q, rv_d, rf_q, rf_d, ra_q, ra_d, wv_q, wv_d, irq_q, irq_d;
  logic [63:0] rpa_q, rpa_d, wa_q, wa_d;
  // Bus slave state
  logic [31:0] rdata_q, rdata_d;
  logic wpend_q, wpend_d;
  logic [7:0] waddr_q, waddr_d;
  logic hready_q, hresp_q;

  // Lookup wires
  logic [2:0] rn;
  logic [TAG_W-1:0] cur_tag;
  logic [5:0] cur_ps;
  logic [TB_ENTRIES-1:0] hit_vec;
  logic [63:0] hpte, hash_addr;
  logic hit, xl_on, key_ok, priv_ok;
  logic need_r, need_w, need_x;

  // Page number bits above the page size take part in the match
  function automatic logic [VPN_W-1:0] cmp_mask(input logic [5:0] ps);
    logic [5:0] p;
    p = (ps < MIN_PS) ? MIN_PS : ps;
    cmp_mask = {VPN_W{1'b1}} << (p - MIN_PS);
  endfunction : cmp_mask

  assign rn = va_q[63:61];
  assign cur_tag = rr_q[rn][TAG_LSB +: TAG_W];
  assign cur_ps = rr_q[rn][PS_LSB +: 6];
  assign need_x = (cls_q == REF_FETCH);
  assign need_w = wr_q && !need_x;
  assign need_r = !wr_q && !need_x;

  // Per-entry comparators; region number is optional
  for (genvar g = 0; g < TB_ENTRIES; g++) begin : g_match
    assign hit_vec[g] = tb_valid_q[g] && (tb_tag_q[g] == cur_tag)
        && (((va_q[60:12] ^ tb_vpn_q[g]) & cmp_mask(tb_pte_q[g][PTE_PS_LSB +: 6])) == '0)
        && (!ctrl_q[CTL_RNM] || (tb_rn_q[g] == rn));
  end

  // First hitting entry wins
  always_comb begin
    hpte = '0;
    for (int i = TB_ENTRIES - 1; i >= 0; i--) begin
      if (hit_vec[i]) begin
        hpte = tb_pte_q[i];
      end
    end
  end
  assign hit = |hit_vec;

  // Lower number is more privileged; the entry sets the least privilege allowed
  assign priv_ok = (pl_q <= hpte[PTE_PL_LSB +: 2]) && (!need_r || hpte[PTE_R])
                   && (!need_w || hpte[PTE_W]) && (!need_x || hpte[PTE_X]);

  // Per-class enable
  always_comb begin
    unique case (cls_q)
      REF_FETCH: xl_on = ctrl_q[CTL_IT];
      REF_DATA: xl_on = ctrl_q[CTL_DT];
      default: xl_on = ctrl_q[CTL_RT];
    endcase
  end

  // Key rights on the hit entry; key is held with the entry tag
  prot_key_check u_key (
    .check_en(ctrl_q[CTL_KEY]),
    .key0(key0_q),
    .key1(key1_q),
    .entry_key(cur_tag),
    .need_r(need_r),
    .need_w(need_w),
    .need_x(need_x),
    .ok(key_ok)
  );

  // Hash entry address for the faulting or walked page
  hash_addr_gen u_hash (
    .base(hbase_q),
    .tag(cur_tag),
    .page_number_field(va_q[60:12]),
    .addr(hash_addr)
  );

  // Sequencer and translation buffer next state
  always_comb begin
    logic [5:0] ps;
    logic [63:0] omask;
    logic fault;
    ps = (hpte[PTE_PS_LSB +: 6] < MIN_PS) ? MIN_PS : hpte[PTE_PS_LSB +: 6];
    omask = (64'h0000_0000_0000_0001 << ps) - 64'h0000_0000_0000_0001;
    fault = 1'b0;
    state_d = state_q;
    va_d = va_q;
    cls_d = cls_q;
    pl_d = pl_q;
    wr_d = wr_q;
    walked_d = walked_q;
    rdy_d = 1'b0;
    rv_d = 1'b0;
    rf_d = rf_q;
    ra_d = ra_q;
    rpa_d = rpa_q;
    wv_d = wv_q;
    wa_d = wa_q;
    vic_d = vic_q;
    st_set = '0;
    tb_valid_d = tb_valid_q;
    tb_rn_d = tb_rn_q;
    tb_tag_d = tb_tag_q;
    tb_vpn_d = tb_vpn_q;
    tb_pte_d = tb_pte_q;
    unique case (state_q)
      S_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid && rdy_q) begin
          rdy_d = 1'b0;
          // Legacy addresses are widened with zeros
          va_d = req_legacy32 ? {32'h0000_0000, req_vaddr[31:0]} : req_vaddr;
          cls_d = req_class;
          pl_d = req_pl;
          wr_d = req_write;
          walked_d = 1'b0;
          state_d = S_LOOK;
        end
      end
      S_LOOK: begin
        if (!xl_on) begin
          // No lookup and no fault when off
          rv_d = 1'b1;
          rf_d = 1'b0;
          ra_d = 1'b0;
          rpa_d = va_q;
          st_set[ST_DONE] = 1'b1;
          state_d = S_IDLE;
        end else if (hit) begin
          rv_d = 1'b1;
          rf_d = !(priv_ok && key_ok);
          ra_d = !(priv_ok && key_ok);
          fault = !(priv_ok && key_ok);
          // Frame above the page size, offset untouched below
          rpa_d = ({hpte[63:12], 12'h000} & ~omask) | (va_q & omask);
          st_set[ST_DONE] = priv_ok && key_ok;
          st_set[ST_ACC] = fault;
          state_d = S_IDLE;
        end else if (rr_q[rn][RR_WALK_BIT] && !walked_q) begin
          wv_d = 1'b1;
          wa_d = hash_addr;
          state_d = S_WALK;
        end else begin
          // Nothing is changed that a retry would need
          rv_d = 1'b1;
          rf_d = 1'b1;
          ra_d = 1'b0;
          rpa_d = '0;
          fault = 1'b1;
          st_set[ST_MISS] = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_WALK: begin
        if (walk_ack) begin
          wv_d = 1'b0;
          walked_d = 1'b1;
          state_d = S_LOOK;
          if (walk_data[PTE_PRESENT]) begin
            // Install then look up again
            tb_valid_d[vic_q] = 1'b1;
            tb_rn_d[vic_q] = rn;
            tb_tag_d[vic_q] = cur_tag;
            tb_vpn_d[vic_q] = va_q[60:12];
            tb_pte_d[vic_q] = walk_data;
            vic_d = vic_q + 2'd1;
            st_set[ST_WALK] = 1'b1;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
    // Software insert through the command register
    if (wpend_q && waddr_q == OFS_INS_CMD) begin
      tb_valid_d[hwdata[1:0]] = pte_q[PTE_PRESENT];
      tb_rn_d[hwdata[1:0]] = ins_va_q[63:61];
      tb_tag_d[hwdata[1:0]] = rr_q[ins_va_q[63:61]][TAG_LSB +: TAG_W];
      tb_vpn_d[hwdata[1:0]] = ins_va_q[60:12];
      tb_pte_d[hwdata[1:0]] = {pte_q[63:12], ins_info_q[PS_LSB +: 6], pte_q[5:0]};
    end
    // Fault side effects on the capture registers
    hea_d = hea_q;
    if (fault && ctrl_q[CTL_IC]) begin
      hea_d = hash_addr[63:2];
    end
  end

  // Register file next state; hardware fault capture beats a software write
  always_comb begin
    logic [31:0] wd;
    wd = hwdata;
    rr_d = rr_q;
    ctrl_d = ctrl_q;
    hbase_d = hbase_q;
    ins_info_d = ins_info_q;
    ins_va_d = ins_va_q;
    pte_d = pte_q;
    key0_d = key0_q;
    key1_d = key1_q;
    en_d = en_q;
    if (wpend_q) begin
      if (waddr_q < OFS_CTRL) begin
        rr_d[waddr_q[4:2]] = wd;
      end
      unique case (waddr_q)
        OFS_CTRL: ctrl_d = wd;
        OFS_HBASE_LO: hbase_d[31:0] = wd;
        OFS_HBASE_HI: hbase_d[63:32] = wd;
        OFS_INS_INFO: ins_info_d = wd;
        OFS_INS_VA_LO: ins_va_d[31:0] = wd;
        OFS_INS_VA_HI: ins_va_d[63:32] = wd;
        OFS_PTE_LO: pte_d[31:0] = wd;
        OFS_PTE_HI: pte_d[63:32] = wd;
        OFS_KEY0: key0_d = wd;
        OFS_KEY1: key1_d = wd;
        OFS_ENABLE: en_d = wd[3:0];
        default: ;
      endcase
    end
    if ((st_set[ST_MISS] || st_set[ST_ACC])) begin
      ins_info_d[PS_LSB +: 6] = cur_ps;
      ins_info_d[TAG_LSB +: TAG_W] = cur_tag;
    end
    // Set wins over a clear in the same cycle
    st_d = (st_q & ~((wpend_q && waddr_q == OFS_CLEAR) ? wd[3:0] : 4'h0)) | st_set;
    irq_d = |(st_d & en_d);
  end

  // Bus slave: address phase captured, reads answered in the data phase
  always_comb begin
    logic [7:0] a;
    a = haddr[7:0];
    wpend_d = hsel && hready && htrans[1] && hwrite;
    waddr_d = a;
    rdata_d = rdata_q;
    if (hsel && hready && htrans[1] && !hwrite) begin
      rdata_d = 32'h0000_0000;
      if (a < OFS_CTRL) begin
        rdata_d = rr_q[a[4:2]];
      end
      unique case (a)
        OFS_CTRL: rdata_d = ctrl_q;
        OFS_HBASE_LO: rdata_d = hbase_q[31:0];
        OFS_HBASE_HI: rdata_d = hbase_q[63:32];
        OFS_HEA_LO: rdata_d = {hea_q[31:2], 2'b00};
        OFS_HEA_HI: rdata_d = hea_q[63:32];
        OFS_INS_INFO: rdata_d = ins_info_q;
        OFS_INS_VA_LO: rdata_d = ins_va_q[31:0];
        OFS_INS_VA_HI: rdata_d = ins_va_q[63:32];
        OFS_PTE_LO: rdata_d = pte_q[31:0];
        OFS_PTE_HI: rdata_d = pte_q[63:32];
        OFS_KEY0: rdata_d = key0_q;
        OFS_KEY1: rdata_d = key1_q;
        OFS_STATUS: rdata_d = {28'h000_0000, st_q};
        OFS_ENABLE: rdata_d = {28'h000_0000, en_q};
        default: ;
      endcase
    end
  end

  // All state registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < REGION_CNT; i++) begin
        rr_q[i] <= RR_RESET;
      end
      for (int i = 0; i < TB_ENTRIES; i++) begin
        tb_valid_q[i] <= 1'b0;
        tb_rn_q[i] <= '0;
        tb_tag_q[i] <= '0;
        tb_vpn_q[i] <= '0;
        tb_pte_q[i] <= '0;
      end
      ctrl_q <= CTRL_RESET;
      hbase_q <= '0;
      hea_q <= '0;
      ins_info_q <= '0;
      ins_va_q <= '0;
      pte_q <= '0;
      key0_q <= '0;
      key1_q <= '0;
      st_q <= '0;
      en_q <= '0;
      vic_q <= '0;
      state_q <= S_IDLE;
      va_q <= '0;
      cls_q <= '0;
      pl_q <= '0;
      wr_q <= 1'b0;
      walked_q <= 1'b0;
      rdy_q <= 1'b0;
      rv_q <= 1'b0;
      rf_q <= 1'b0;
      ra_q <= 1'b0;
      rpa_q <= '0;
      wv_q <= 1'b0;
      wa_q <= '0;
      irq_q <= 1'b0;
      rdata_q <= '0;
      wpend_q <= 1'b0;
      waddr_q <= '0;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end else begin
      rr_q <= rr_d;
      tb_valid_q <= tb_valid_d;
      tb_rn_q <= tb_rn_d;
      tb_tag_q <= tb_tag_d;
      tb_vpn_q <= tb_vpn_d;
      tb_pte_q <= tb_pte_d;
      ctrl_q <= ctrl_d;
      hbase_q <= hbase_d;
      hea_q <= hea_d;
      ins_info_q <= ins_info_d;
      ins_va_q <= ins_va_d;
      pte_q <= pte_d;
      key0_q <= key0_d;
      key1_q <= key1_d;
      st_q <= st_d;
      en_q <= en_d;
      vic_q <= vic_d;
      state_q <= state_d;
      va_q <= va_d;
      cls_q <= cls_d;
      pl_q <= pl_d;
      wr_q <= wr_d;
      walked_q <= walked_d;
      rdy_q <= rdy_d;
      rv_q <= rv_d;
      rf_q <= rf_d;
      ra_q <= ra_d;
      rpa_q <= rpa_d;
      wv_q <= wv_d;
      wa_q <= wa_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      wpend_q <= wpend_d;
      waddr_q <= waddr_d;
      hready_q <= 1'b1;
      hresp_q <= 1'b0;
    end
  end

  // Outputs straight from flops
  assign hrdata = rdata_q;
  assign hreadyout = hready_q;
  assign hresp = hresp_q;
  assign irq = irq_q;
  assign req_ready = rdy_q;
  assign resp_valid = rv_q;
  assign resp_paddr = rpa_q;
  assign resp_fault = rf_q;
  assign resp_access_fault = ra_q;
  assign walk_valid = wv_q;
  assign walk_addr = wa_q;
endmodule : region_virtual_address_translator

// ==== tb/xlate_props.sv ====
// Purpose: Port-level checker for the region translator
// Assumes: Sees only top-level ports; one clock domain
// Notes: Bound to every translator instance below the module
`timescale 1ns/10ps
module xlate_props (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Register bus answer
  input wire logic hreadyout,
  input wire logic hresp,
  // Translation request and answer
  input wire logic req_valid,
  input wire logic [63:0] req_vaddr,
  input wire logic req_ready,
  input wire logic resp_valid,
  input wire logic [63:0] resp_paddr,
  input wire logic resp_fault,
  // Hash table walk port
  input wire logic walk_valid,
  input wire logic [63:0] walk_addr,
  input wire logic walk_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // Offset in flight; no page is below 4 KB
  logic [11:0] off_q;
  logic [11:0] off_d;
  // Taken on an accepted request
  always_comb off_d = (req_valid && req_ready) ? req_vaddr[11:0] : off_q;
  // Offset register
  always_ff @(posedge core_clk) off_q <= off_d;
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_ack; walk_valid && walk_ack; endsequence
  // After a walk returns: lookup again, then answer with no second walk
  sequence s_settle; ##1 !walk_valid ##1 (!walk_valid && resp_valid); endsequence
  property p_answer; s_take |-> ##2 (resp_valid || walk_valid); endproperty
  a_answer: assert property (p_answer) else $error("no answer or walk after a take");
  property p_offset; resp_valid && !resp_fault |-> resp_paddr[11:0] == off_q; endproperty
  a_offset: assert property (p_offset) else $error("page offset changed");
  property p_ready_drop; s_take |=> !req_ready; endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready stayed high after take");
  property p_ready_back; resp_valid |=> req_ready && !resp_valid; endproperty
  a_ready_back: assert property (p_ready_back) else $error("answer not a pulse or no ready");
  property p_walk_hold; walk_valid && !walk_ack |=> walk_valid && $stable(walk_addr); endproperty
  a_walk_hold: assert property (p_walk_hold) else $error("walk read dropped early");
  property p_walk_resp; s_ack |-> s_settle; endproperty
  a_walk_resp: assert property (p_walk_resp) else $error("no answer after walk");
  property p_walk_align; walk_valid |-> walk_addr[2:0] == 3'h0; endproperty
  a_walk_align: assert property (p_walk_align) else $error("walk address misaligned");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus wait or error response");
endmodule : xlate_props
bind region_virtual_address_translator xlate_props i_props (.core_clk, .reset, .hreadyout,
  .hresp, .req_valid, .req_vaddr, .req_ready, .resp_valid, .resp_paddr, .resp_fault,
  .walk_valid, .walk_addr, .walk_ack);

// ==== tb/walk_mem_model.sv ====
// Purpose: Memory holding the hash table, answering walk reads
// Assumes: One outstanding walk read at a time
// Notes: Data is scrambled outside the acknowledge cycle
`timescale 1ns/10ps
module walk_mem_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Walk port
  input wire logic walk_valid,
  input wire logic [63:0] walk_addr,
  output logic walk_ack,
  output logic [63:0] walk_data,
  // Bench control: entry returned, answer delay, last address read
  input wire logic [63:0] entry_word,
  input wire logic [3:0] lag,
  output logic [63:0] seen_addr
);
  int unsigned wait_n = 0;
  // Answer after lag cycles; stale data alternates between the last entry and its inverse
  always @(posedge core_clk) begin
    walk_ack <= 1'b0;
    walk_data <= ~walk_data;
    if (reset) begin
      wait_n <= 0;
      walk_data <= '1;
      seen_addr <= '0;
    end else if (walk_valid && !walk_ack) begin
      seen_addr <= walk_addr;
      if (wait_n >= lag) begin
        walk_ack <= 1'b1;
        walk_data <= entry_word;
        wait_n <= 0;
      end else begin
        wait_n <= wait_n + 1;
      end
    end
  end
endmodule : walk_mem_model

// ==== tb/region_virtual_address_translator_tb.sv ====
// Purpose: Self-checking bench for the region translator
// Assumes: Zero-wait register bus, one request at a time
// Notes: Answers are checked in order from a queue of notes
`timescale 1ns/10ps
module region_virtual_address_translator_tb;
  import xlate_pkg::*;
  logic core_clk = 0, reset = 1, hsel = 0, hwrite = 0, req_valid = 0, req_legacy32 = 0;
  logic req_write = 0, req_ready, resp_valid, resp_fault, resp_access_fault;
  logic hreadyout, hresp, irq, walk_valid, walk_ack;
  logic [1:0] htrans = 0, req_class = 0, req_pl = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [63:0] req_vaddr = 0, resp_paddr, walk_addr, walk_data, seen, pte = 0, va;
  logic [3:0] lag = 0;
  logic [65:0] expq[$];
  logic [65:0] note;
  logic [23:0] tg5, tg6, tg7;
  logic [48:0] page_number_field;
  logic [51:0] fr;
  int errors = 0, checks_done = 0;
  localparam logic [31:0] BASE_LO = 32'h0012_8000;
  localparam logic [65:0] MISS = {64'h0, 2'b10};
  localparam logic [65:0] ACC = {64'h0, 2'b11};
  region_virtual_address_translator i_dut (.core_clk, .reset, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .req_valid,
    .req_class, .req_legacy32, .req_vaddr, .req_write, .req_pl, .req_ready, .resp_valid,
    .resp_paddr, .resp_fault, .resp_access_fault, .walk_valid, .walk_addr, .walk_ack, .walk_data);
  walk_mem_model i_mem (.core_clk, .reset, .walk_valid, .walk_addr, .walk_ack, .walk_data,
    .entry_word(pte), .lag, .seen_addr(seen));
  // Expected answer with no fault
  function automatic logic [65:0] ok(input logic [63:0] p);
    return {p, 2'b00};
  endfunction : ok
  // Hash index from page number and region tag
  function automatic logic [11:0] hidx(input logic [23:0] t, input logic [48:0] p);
    return p[11:0] ^ t[11:0] ^ t[23:12];
  endfunction : hidx
  task automatic check(input logic [63:0] seen_v, input logic [63:0] exp_v, input string what);
    checks_done++;
    if (seen_v !== exp_v) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp_v, seen_v);
    end
  endtask : check
  task automatic complete_run();
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  // One word transfer plus an idle cycle
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    @(posedge core_clk);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(64'(r), 64'(e), "register");
  endtask : rd
  // Insert pte for address v into a slot
  task automatic ins(input logic [63:0] v, input logic [31:0] slot);
    bus(1'b1, OFS_INS_VA_LO, v[31:0]);
    bus(1'b1, OFS_INS_VA_HI, v[63:32]);
    bus(1'b1, OFS_PTE_LO, pte[31:0]);
    bus(1'b1, OFS_PTE_HI, pte[63:32]);
    bus(1'b1, OFS_INS_CMD, slot);
  endtask : ins
  // Note first, then hold the request until taken
  task automatic xl(input logic [1:0] c, input logic l, input logic w, input logic [63:0] v,
                    input logic [1:0] pl, input logic [65:0] e);
    expq.push_back(e);
    req_valid <= 1'b1;
    req_class <= c;
    req_legacy32 <= l;
    req_write <= w;
    req_vaddr <= v;
    req_pl <= pl;
    do @(posedge core_clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    do @(posedge core_clk); while (resp_valid !== 1'b1);
  endtask : xl
  // Clock, 50 ns period
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  // Watchdog
  initial begin
    repeat (8000) @(posedge core_clk);
    errors++;
    complete_run();
  end
  // Compare every answer with the oldest note
  always @(posedge core_clk) begin
    if (resp_valid === 1'b1) begin
      note = expq.pop_front();
      check(64'({resp_fault, resp_access_fault}), 64'(note[1:0]), "fault");
      if (note[1] === 1'b0) check(resp_paddr, note[65:2], "paddr");
    end
  end
  initial begin
    void'($urandom(35407));
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_REGION0 + 8'h1C, RR_RESET);
    rd(8'hFC, 32'h0);
    // Translation off: straight through, legacy addresses widened
    for (int c = 0; c < 3; c++) begin
      va = {$urandom, $urandom};
      xl(c[1:0], 1'b0, 1'b0, va, 2'h0, ok(va));
      xl(c[1:0], 1'b1, 1'b0, va, 2'h0, ok({32'h0, va[31:0]}));
    end
    // Data class on only; collection off keeps the hash address
    bus(1'b1, OFS_CTRL, 32'h0000_0002);
    xl(2'h1, 1'b0, 1'b0, va, 2'h0, MISS);
    xl(2'h0, 1'b0, 1'b0, va, 2'h0, ok(va));
    rd(OFS_HEA_LO, 32'h0);
    tg5 = 24'($urandom);
    tg6 = 24'($urandom);
    tg7 = 24'($urandom);
    page_number_field = 49'({$urandom, $urandom});
    fr = 52'({$urandom, $urandom});
    bus(1'b1, OFS_HBASE_LO, BASE_LO);
    bus(1'b1, OFS_HBASE_HI, 32'h0000_00A5);
    bus(1'b1, OFS_REGION0 + 8'h10, {tg5, 8'h30});
    bus(1'b1, OFS_REGION0 + 8'h14, {tg5, 8'h30});
    bus(1'b1, OFS_REGION0 + 8'h18, {tg6, 8'h30});
    bus(1'b1, OFS_REGION0 + 8'h1C, {tg7, 8'h31});
    bus(1'b1, OFS_CTRL, 32'h0000_000F);
    bus(1'b1, OFS_INS_INFO, {tg5, 8'h30});
    pte = {fr, 12'h33B};
    va = {3'd5, page_number_field, 12'($urandom)};
    ins(va, 32'h0);
    xl(2'h1, 1'b0, 1'b0, va, 2'h0, ok({fr, va[11:0]}));
    xl(2'h1, 1'b0, 1'b0, {3'd4, va[60:0]}, 2'h0, ok({fr, va[11:0]}));
    xl(2'h2, 1'b0, 1'b0, va, 2'h2, ACC);
    xl(2'h1, 1'b0, 1'b0, {3'd6, va[60:0]}, 2'h0, MISS);
    rd(OFS_INS_INFO, {tg6, 8'h30});
    rd(OFS_HEA_LO, {BASE_LO[31:15], hidx(tg6, page_number_field), 3'h0});
    rd(OFS_HEA_HI, 32'h0000_00A5);
    bus(1'b1, OFS_CTRL, 32'h0000_001F);
    xl(2'h1, 1'b0, 1'b0, {3'd4, va[60:0]}, 2'h0, MISS);
    // Interrupt masked, enabled, cleared
    check(64'(irq), 64'h0, "irq");
    bus(1'b1, OFS_ENABLE, 32'h0000_0001);
    check(64'(irq), 64'h1, "irq");
    bus(1'b1, OFS_CLEAR, 32'h0000_0001);
    check(64'(irq), 64'h0, "irq");
    // Key check: no key, read key only, then a write
    bus(1'b1, OFS_CTRL, 32'h0000_002F);
    xl(2'h1, 1'b0, 1'b0, va, 2'h0, ACC);
    bus(1'b1, OFS_KEY1, {tg5, 8'h03});
    xl(2'h1, 1'b0, 1'b0, va, 2'h0, ok({fr, va[11:0]}));
    xl(2'h1, 1'b0, 1'b1, va, 2'h0, ACC);
    // Walk installs, then a repeat hits the buffer
    bus(1'b1, OFS_CTRL, 32'h0000_000F);
    page_number_field = 49'({$urandom, $urandom});
    fr = 52'({$urandom, $urandom});
    lag = 4'($urandom);
    pte = {fr, 12'h33F};
    va = {3'd7, page_number_field, 12'($urandom)};
    xl(2'h0, 1'b0, 1'b0, va, 2'h3, ok({fr, va[11:0]}));
    check(seen, {32'h0000_00A5, BASE_LO[31:15], hidx(tg7, page_number_field), 3'h0}, "walk");
    pte = ~pte;
    lag = 4'h0;
    xl(2'h0, 1'b0, 1'b0, va, 2'h3, ok({fr, va[11:0]}));
    // Entry absent in memory: fault, software insert, restart
    va[60:12] = ~page_number_field;
    xl(2'h0, 1'b0, 1'b0, va, 2'h0, MISS);
    pte = {fr, 12'h33F};
    ins(va, 32'h1);
    xl(2'h0, 1'b0, 1'b0, va, 2'h0, ok({fr, va[11:0]}));
    complete_run();
  end
endmodule : region_virtual_address_translator_tb
